// *** verilog/diffserv_map_pkg.sv ***
/*
 * Constants for the DiffServ code point to frame priority map: register
 * offsets, field layout, reset values and the address decode helpers.
 * Assumes an 8-bit register address space shared with other switch blocks.
 */
package diffserv_map_pkg;

    // Geometry of the map
    localparam int REG_W = 8;
    localparam int ENTRY_W = 2;
    localparam int ENTRIES_PER_REG = 4;
    localparam int CODE_BITS = 6;
    localparam int MAP_REGS = 16;
    localparam int ADDR_W = 8;

    // Code point position inside the TOS / Traffic Class byte
    localparam int DSCP_MSB = 7;
    localparam int DSCP_LSB = 2;

    // Register offsets, four code points per register
    localparam logic [7:0] OFS_00_03 = 8'h90;
    localparam logic [7:0] OFS_04_07 = 8'h91;
    localparam logic [7:0] OFS_08_0B = 8'h92;
    localparam logic [7:0] OFS_0C_0F = 8'h93;
    localparam logic [7:0] OFS_10_13 = 8'h94;
    localparam logic [7:0] OFS_14_17 = 8'h95;
    localparam logic [7:0] OFS_18_1B = 8'h96;
    localparam logic [7:0] OFS_1C_1F = 8'h97;
    localparam logic [7:0] OFS_20_23 = 8'h98;
    localparam logic [7:0] OFS_24_27 = 8'h99;
    localparam logic [7:0] OFS_28_2B = 8'h9A;
    localparam logic [7:0] OFS_2C_2F = 8'h9B;
    localparam logic [7:0] OFS_30_33 = 8'h9C;
    localparam logic [7:0] OFS_34_37 = 8'h9D;
    localparam logic [7:0] OFS_38_3B = 8'h9E;
    localparam logic [7:0] OFS_3C_3F = 8'h9F;

    // Values after reset and on unmapped reads
    localparam logic [7:0] MAP_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic [1:0] PRIO_NONE = 2'h0;

    // Address falls inside the map window
    function automatic logic map_hit(input logic [7:0] addr);
        map_hit = (addr >= OFS_00_03) && (addr <= OFS_3C_3F);
    endfunction : map_hit

    // Register index of an address inside the window
    function automatic logic [3:0] map_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - OFS_00_03;
        map_index = diff[3:0];
    endfunction : map_index

endpackage : diffserv_map_pkg

// *** verilog/dscp_entry_select.sv ***
/*
 * Picks the priority entry addressed by a code point out of the
 * flattened map. Purely combinational; the caller registers the result.
 * Assumes entries are packed lowest code point in the lowest bits.
 */
`timescale 1ns/10ps
module dscp_entry_select import diffserv_map_pkg::*; #(
    parameter int PRIO_W = ENTRY_W,
    parameter int CODE_W = CODE_BITS
) (
    input wire logic [(PRIO_W << CODE_W)-1:0] map_flat,
    input wire logic [CODE_W-1:0] code,
    output logic [PRIO_W-1:0] prio
);

    // Entry n sits at bits n*PRIO_W upward
    always_comb begin
        prio = map_flat[int'(code) * PRIO_W +: PRIO_W];
    end

endmodule : dscp_entry_select

// *** verilog/ip_diffserv_priority_map.sv ***
/*
 * DiffServ code point to frame priority map of the switch: sixteen 8-bit
 * read/write registers, each holding four 2-bit priorities, and the
 * per-frame lookup that turns a TOS / Traffic Class byte into a priority.
 * Assumes the register access port and the frame parser sit outside and
 * drive the inputs synchronous to clk; one request per cycle on each port.
 */
// Operation
// RQ1: IP frames index the map with TOS byte bits 7:2; entry gives priority.
// RQ2: Code point 0x00 takes bits 1:0 of the first map register.
// RQ3: Code point 0x01 takes bits 3:2 of the first map register.
// RQ4: Code point 0x02 takes bits 5:4 of the first map register.
// RQ5: Offset 0x91 holds code points 0x04 to 0x07, lowest in bits 1:0.
// RQ6: Offset 0x92 holds code points 0x08 to 0x0B, same packing.
// RQ7: Offset 0x94 holds code points 0x10 to 0x13, same packing.
// RQ8: Offset 0x96 holds code points 0x18 to 0x1B, same packing.
// RQ9: Offset 0x98 holds code points 0x20 to 0x23, same packing.
// RQ10: Offset 0x9A holds code points 0x28 to 0x2B, same packing.
// RQ11: Each next offset takes next four code points, through 0x9C for 0x30-0x33.
// RQ12: Every entry is software read/write and resets to zero.
// RQ13: Code point 0x03 takes bits 7:6 of the first map register.
// RQ14: Map continues to offset 0x9F; its bits 7:6 serve code point 0x3F.
// RQ15: Mapped priority applies only to IP frames on ports with IP priority on.
`timescale 1ns/10ps
module ip_diffserv_priority_map import diffserv_map_pkg::*; #(
    parameter int PRIO_W = ENTRY_W,
    parameter int CODE_W = CODE_BITS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [REG_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [REG_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic frm_valid,
    input wire logic frm_is_ip,
    input wire logic frm_ip_prio_en,
    input wire logic [7:0] frm_tos,
    output logic prio_valid,
    output logic prio_hit,
    output logic [PRIO_W-1:0] prio_value
);

    // Refuse geometries the fixed register layout cannot hold
    if (PRIO_W * ENTRIES_PER_REG != REG_W) begin : g_bad_prio_w
        $error("priority width does not pack into an 8-bit register");
    end
    if ((PRIO_W << CODE_W) != MAP_REGS * REG_W) begin : g_bad_code_w
        $error("code point width does not match sixteen map registers");
    end

    // Map storage and its flattened view
    logic [REG_W-1:0] map_q [MAP_REGS];
    logic [REG_W-1:0] next_map [MAP_REGS];
    logic [MAP_REGS*REG_W-1:0] map_flat;

    // Write decode
    logic wr_hit;
    logic [3:0] wr_index;

    // Lookup path
    logic [CODE_W-1:0] code;
    logic ip_take;
    logic [PRIO_W-1:0] sel_prio;
    logic next_prio_valid;
    logic next_prio_hit;
    logic [PRIO_W-1:0] next_prio_value;

    // Read path
    logic [REG_W-1:0] next_rdata;
    logic next_rvalid;

    // Address decode shared by every register slot
    assign wr_hit = reg_wr && map_hit(reg_addr);
    assign wr_index = map_index(reg_addr);

    // One register per four code points; offset order follows code order
    for (genvar g = 0; g < MAP_REGS; g++) begin : g_map
        // Software write replaces the whole byte
        always_comb begin
            next_map[g] = map_q[g];
            if (wr_hit && (wr_index == 4'(g))) begin
                next_map[g] = reg_wdata; // [RQ5] [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ14]
            end
        end

        // Storage, cleared to priority zero on reset
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                map_q[g] <= MAP_RESET; // [RQ12]
            end else begin
                map_q[g] <= next_map[g];
            end
        end

        // Lowest register holds the lowest code points
        assign map_flat[g*REG_W +: REG_W] = map_q[g]; // [RQ11]
    end

    // Code point sits in the upper six bits of the TOS byte
    assign code = frm_tos[DSCP_MSB:DSCP_LSB]; // [RQ1]
    assign ip_take = frm_valid && frm_is_ip && frm_ip_prio_en; // [RQ15]

    // Entry at bits code*2 upward, so 0x00 is bits 1:0 and 0x03 bits 7:6
    dscp_entry_select #(
        .PRIO_W(PRIO_W),
        .CODE_W(CODE_W)
    ) u_select (
        .map_flat(map_flat),
        .code(code),
        .prio(sel_prio) // [RQ2] [RQ3] [RQ4] [RQ13]
    );

    // Next lookup result; frames outside IP priority pass unmapped
    always_comb begin
        next_prio_valid = frm_valid;
        next_prio_hit = ip_take; // [RQ15]
        next_prio_value = PRIO_NONE;
        if (ip_take) begin
            next_prio_value = sel_prio; // [RQ1]
        end
    end

    // Lookup result, one cycle after the frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_valid <= 1'b0;
            prio_hit <= 1'b0;
            prio_value <= PRIO_NONE;
        end else begin
            prio_valid <= next_prio_valid;
            prio_hit <= next_prio_hit;
            prio_value <= next_prio_value;
        end
    end

    // Read returns the stored byte; unmapped addresses read zero
    always_comb begin
        next_rvalid = reg_rd;
        next_rdata = reg_rdata;
        if (reg_rd) begin
            if (map_hit(reg_addr)) begin
                next_rdata = map_q[map_index(reg_addr)]; // [RQ12]
            end else begin
                next_rdata = UNMAPPED_DATA;
            end
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rvalid <= 1'b0;
            reg_rdata <= MAP_RESET;
        end else begin
            reg_rvalid <= next_rvalid;
            reg_rdata <= next_rdata;
        end
    end

    // Any enabled IP frame gets the entry its code point selects
    a_lookup_any_code: assert property ( // [RQ1]
        @(posedge clk) disable iff (!rst_n)
        ip_take |=> prio_valid && prio_hit && (prio_value == $past(map_flat[
            int'(frm_tos[7:2]) * 2 +: 2]))
    ) else $error("lookup result differs from selected map entry");

    // Code point 0x00 from the first register, low pair
    a_code00_entry: assert property ( // [RQ2]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h00) |=> prio_value == $past(map_q[0][1:0])
    ) else $error("code point 0x00 not taken from bits 1:0");

    // Code point 0x01 from the first register, bits 3:2
    a_code01_entry: assert property ( // [RQ3]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h01) |=> prio_value == $past(map_q[0][3:2])
    ) else $error("code point 0x01 not taken from bits 3:2");

    // Code point 0x02 from the first register, bits 5:4
    a_code02_entry: assert property ( // [RQ4]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h02) |=> prio_value == $past(map_q[0][5:4])
    ) else $error("code point 0x02 not taken from bits 5:4");

    // Code point 0x03 from the first register, bits 7:6
    a_code03_entry: assert property ( // [RQ13]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h03) |=> prio_value == $past(map_q[0][7:6])
    ) else $error("code point 0x03 not taken from bits 7:6");

    // Byte written at 0x91 steers code point 0x07 two cycles on
    a_reg91_code07: assert property ( // [RQ5]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h91) ##1 (ip_take && frm_tos[7:2] == 6'h07 && !reg_wr)
        |=> prio_value == $past(reg_wdata[7:6], 2)
    ) else $error("offset 0x91 bits 7:6 do not serve code point 0x07");

    // Code point 0x08 from offset 0x92 low pair
    a_reg92_code08: assert property ( // [RQ6]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h92) ##1 (ip_take && frm_tos[7:2] == 6'h08 && !reg_wr)
        |=> prio_value == $past(reg_wdata[1:0], 2)
    ) else $error("offset 0x92 bits 1:0 do not serve code point 0x08");

    // Code point 0x13 from offset 0x94 high pair
    a_reg94_code13: assert property ( // [RQ7]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h13) |=> prio_value == $past(map_q[4][7:6])
    ) else $error("code point 0x13 not taken from offset 0x94 bits 7:6");

    // Code point 0x18 from offset 0x96 low pair
    a_reg96_code18: assert property ( // [RQ8]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h18) |=> prio_value == $past(map_q[6][1:0])
    ) else $error("code point 0x18 not taken from offset 0x96 bits 1:0");

    // Code point 0x23 from offset 0x98 high pair
    a_reg98_code23: assert property ( // [RQ9]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h23) |=> prio_value == $past(map_q[8][7:6])
    ) else $error("code point 0x23 not taken from offset 0x98 bits 7:6");

    // Code point 0x28 from offset 0x9A low pair
    a_reg9a_code28: assert property ( // [RQ10]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h28) |=> prio_value == $past(map_q[10][1:0])
    ) else $error("code point 0x28 not taken from offset 0x9A bits 1:0");

    // Code point 0x33 from offset 0x9C high pair
    a_reg9c_code33: assert property ( // [RQ11]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h9C) ##1 (ip_take && frm_tos[7:2] == 6'h33 && !reg_wr)
        |=> prio_value == $past(reg_wdata[7:6], 2)
    ) else $error("offset 0x9C bits 7:6 do not serve code point 0x33");

    // Code point 0x3F from offset 0x9F high pair
    a_reg9f_code3f: assert property ( // [RQ14]
        @(posedge clk) disable iff (!rst_n)
        (ip_take && frm_tos[7:2] == 6'h3F) |=> prio_value == $past(map_q[15][7:6])
    ) else $error("code point 0x3F not taken from offset 0x9F bits 7:6");

    // Written byte reads back on a read in the next cycle
    a_write_readback: assert property ( // [RQ12]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && map_hit(reg_addr)) ##1 (reg_rd && !reg_wr && $stable(reg_addr))
        |=> reg_rvalid && (reg_rdata == $past(reg_wdata, 2))
    ) else $error("map register does not read back the written byte");

    // Unmapped reads answer zero
    a_unmapped_read: assert property ( // [RQ12]
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && !map_hit(reg_addr)) |=> reg_rvalid && reg_rdata == 8'h00
    ) else $error("unmapped read did not return zero");

    // Non-IP or disabled frames bypass the map
    a_bypass_non_ip: assert property ( // [RQ15]
        @(posedge clk) disable iff (!rst_n)
        (frm_valid && !(frm_is_ip && frm_ip_prio_en))
        |=> prio_valid && !prio_hit && prio_value == 2'h0
    ) else $error("frame outside IP priority received a mapped value");

    // No result without a frame
    a_idle_no_result: assert property ( // [RQ15]
        @(posedge clk) disable iff (!rst_n)
        !frm_valid |=> !prio_valid && !prio_hit
    ) else $error("lookup result without a frame");

    // Byte written at 0x9D lands in the fourteenth register
    a_write_lands_9d: assert property ( // [RQ14]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h9D) |=> map_q[13] == $past(reg_wdata)
    ) else $error("write to offset 0x9D did not land in its register");

    // Byte written at 0x93 lands in the fourth register
    a_write_lands_93: assert property ( // [RQ11]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h93) |=> map_q[3] == $past(reg_wdata)
    ) else $error("write to offset 0x93 did not land in its register");

    // Byte written at 0x93 steers code point 0x0C two cycles on
    a_reg93_code0c: assert property ( // [RQ11]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == 8'h93) ##1 (ip_take && frm_tos[7:2] == 6'h0C && !reg_wr)
        |=> prio_value == $past(reg_wdata[1:0], 2)
    ) else $error("offset 0x93 bits 1:0 do not serve code point 0x0C");

    // Writes outside the window leave the map alone
    a_outside_write_kept: assert property ( // [RQ11]
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && !map_hit(reg_addr)) |=> $stable(map_flat)
    ) else $error("write outside the map window changed the map");

    // Without a read, no answer and the read data holds
    a_read_idle_quiet: assert property ( // [RQ12]
        @(posedge clk) disable iff (!rst_n)
        !reg_rd |=> !reg_rvalid && $stable(reg_rdata)
    ) else $error("read answer or data changed without a read");

    // Read at 0x9F returns the last map register
    a_read_reg9f_data: assert property ( // [RQ14]
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == 8'h9F) |=> reg_rvalid && reg_rdata == $past(map_q[15])
    ) else $error("read at offset 0x9F did not return its register");

endmodule : ip_diffserv_priority_map

// *** test/testbench.sv ***
/*
 * Self-checking bench for the DiffServ code point priority map: reset
 * values, register read-back, the full code point lookup and the bypass.
 * Assumes the strobe register port and one-cycle lookup of the hand-over.
 */
`timescale 1ns/10ps
module testbench import diffserv_map_pkg::*;;
    logic clk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic frm_valid;
    logic frm_is_ip;
    logic frm_ip_prio_en;
    logic [7:0] frm_tos;
    logic prio_valid;
    logic prio_hit;
    logic [1:0] prio_value;
    int n_fail;
    int num_checks;
    logic [7:0] model [16];

    ip_diffserv_priority_map dut (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .frm_valid(frm_valid), .frm_is_ip(frm_is_ip),
        .frm_ip_prio_en(frm_ip_prio_en), .frm_tos(frm_tos),
        .prio_valid(prio_valid), .prio_hit(prio_hit), .prio_value(prio_value)
    );

    // Free-running core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One write strobe, launched just after an edge
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask : reg_write

    // One read strobe; the answer is registered at the taking edge
    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, exp);
        // Answer lasts one cycle, data holds until the next read
        @(posedge clk);
        #1 check({7'h00, reg_rvalid}, 8'h00);
        check(reg_rdata, exp);
    endtask : reg_read

    // One frame header; result comes one cycle later
    task automatic lookup(input logic [7:0] tos, input logic ip, input logic en,
                          input logic [1:0] exp_value, input logic exp_hit);
        frm_tos = tos;
        frm_is_ip = ip;
        frm_ip_prio_en = en;
        frm_valid = 1'b1;
        @(posedge clk);
        #1 frm_valid = 1'b0;
        check({6'h00, prio_hit, prio_valid}, {6'h00, exp_hit, 1'b1});
        check({6'h00, prio_value}, {6'h00, exp_value});
        // Result lasts one cycle only
        @(posedge clk);
        #1 check({4'h0, prio_value, prio_hit, prio_valid}, 8'h00);
    endtask : lookup

    // All registers and unmapped places read zero after reset
    task automatic test_reset_values();
        for (int i = 0; i < 16; i++) begin
            reg_read(OFS_00_03 + 8'(i), MAP_RESET);
            lookup({6'(i * 4), 2'h0}, 1'b1, 1'b1, PRIO_NONE, 1'b1);
        end
        reg_read(8'h8F, UNMAPPED_DATA);
        reg_read(8'hA0, UNMAPPED_DATA);
        $display("test reset values done");
    endtask : test_reset_values

    // Distinct pattern in every register, one by one, then read back
    task automatic test_register_rw();
        for (int i = 0; i < 16; i++) begin
            model[i] = {4'(i), ~4'(i)} ^ 8'h3C;
            reg_write(OFS_00_03 + 8'(i), model[i]);
        end
        reg_write(8'h8F, 8'hFF);
        reg_write(8'hA0, 8'hFF);
        for (int i = 0; i < 16; i++) begin
            reg_read(OFS_00_03 + 8'(i), model[i]);
        end
        $display("test register rw done");
    endtask : test_register_rw

    // Every code point picks its bit pair; low TOS bits must not matter
    task automatic test_full_lookup();
        logic [1:0] exp;
        for (int n = 0; n < 64; n++) begin
            exp = 2'(model[n / 4] >> (2 * (n % 4)));
            lookup({6'(n), 2'(n)}, 1'b1, 1'b1, exp, 1'b1);
        end
        // Corner entries of named registers
        lookup(8'h4F, 1'b1, 1'b1, 2'(model[4] >> 6), 1'b1);
        lookup(8'h60, 1'b1, 1'b1, 2'(model[6]), 1'b1);
        lookup(8'h8C, 1'b1, 1'b1, 2'(model[8] >> 6), 1'b1);
        lookup(8'hA0, 1'b1, 1'b1, 2'(model[10]), 1'b1);
        lookup(8'hCF, 1'b1, 1'b1, 2'(model[12] >> 6), 1'b1);
        lookup(8'hFF, 1'b1, 1'b1, 2'(model[15] >> 6), 1'b1);
        $display("test full lookup done");
    endtask : test_full_lookup

    // Non-IP frames and disabled ports bypass the map
    task automatic test_bypass();
        reg_write(OFS_3C_3F, 8'hFF);
        lookup(8'hFC, 1'b0, 1'b1, PRIO_NONE, 1'b0);
        lookup(8'hFC, 1'b1, 1'b0, PRIO_NONE, 1'b0);
        lookup(8'hFC, 1'b0, 1'b0, PRIO_NONE, 1'b0);
        lookup(8'hFC, 1'b1, 1'b1, 2'h3, 1'b1);
        @(posedge clk);
        #1 check({6'h00, prio_hit, prio_valid}, 8'h00);
        $display("test bypass done");
    endtask : test_bypass

    // Write, then at once a lookup and a read of the same register
    task automatic write_then_use(input logic [7:0] addr, input logic [7:0] data,
                                  input logic [7:0] tos, input logic [1:0] exp_prio);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        frm_tos = tos;
        frm_is_ip = 1'b1;
        frm_ip_prio_en = 1'b1;
        frm_valid = 1'b1;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 frm_valid = 1'b0;
        reg_rd = 1'b0;
        check({6'h00, prio_value}, {6'h00, exp_prio});
        check(reg_rdata, data);
        @(posedge clk);
        #1;
    endtask : write_then_use

    // New entries serve frames from the very next cycle
    task automatic test_write_then_use();
        write_then_use(OFS_04_07, 8'hC0, 8'h1F, 2'h3);
        write_then_use(OFS_08_0B, 8'h02, 8'h21, 2'h2);
        write_then_use(OFS_0C_0F, 8'h01, 8'h32, 2'h1);
        write_then_use(OFS_30_33, 8'h80, 8'hCE, 2'h2);
        $display("test write then use done");
    endtask : test_write_then_use

    // Reset in mid-run clears written entries
    task automatic test_mid_reset();
        reg_write(OFS_3C_3F, 8'hFF);
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        check({6'h00, prio_hit, prio_valid}, 8'h00);
        reg_read(OFS_3C_3F, MAP_RESET);
        lookup(8'hFF, 1'b1, 1'b1, PRIO_NONE, 1'b1);
        $display("test mid reset done");
    endtask : test_mid_reset

    // Verdict and end of run
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        n_fail = 0;
        num_checks = 0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
        frm_valid = 1'b0;
        frm_is_ip = 1'b0;
        frm_ip_prio_en = 1'b0;
        frm_tos = 8'h00;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        test_reset_values();
        test_register_rw();
        test_full_lookup();
        test_write_then_use();
        test_bypass();
        test_mid_reset();
        complete_run();
    end

    // Watchdog, far beyond the few hundred cycles of the tests
    initial begin
        #50000;
        n_fail++;
        complete_run();
    end
endmodule : testbench
